// ---- design/wtu_watchdog.sv ----
// Watchdog time-out unit: AXI4-Lite register slave, time-out sequencing,
// nonmaskable interrupt and system reset request.
// Assumes a gated peripheral clock and a synchronous hardware reset.
//
// Summary of operation
// - A 32-bit down counter times out on reaching zero after enabling.
// - Enabling the counter also enables the time-out interrupt.
// - After the first time-out the counter reloads and counts on.
// - Second zero with interrupt pending and reset enabled asserts system reset.
// - Clearing the interrupt before second time-out reloads the counter.
// - Writing the reload value while counting loads it into the counter at once.
// - Reload writes keep a pending interrupt; only clear writes clear it.
// - Interrupt and reset generation each have their own enable.
// - Enabling the interrupt preloads the counter from the reload value.
// - The interrupt is nonmaskable; the alternative action is system reset.
// - Setting interrupt enable starts the watchdog and locks the control register.
// - Any write other than the unlock key to the lock register locks all other registers.
// - Writing the unlock key to the lock register unlocks the registers.
// - Any clear write while unlocked clears the interrupt and reloads the counter.
// - A reload value of zero raises the interrupt at once.
// - Masked status is raw interrupt AND interrupt enable.
// - Control writes are ignored once interrupt enable is set, until reset.
`timescale 1ns/1ps
module wtu_watchdog #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // Write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // Write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // Read data channel
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // System side
  output logic                   nmi_request,
  output logic                   system_reset_request
);

  // ----------------------------------------
  // Types and declarations
  // ----------------------------------------
  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_RUN     = 2'b01,
    WD_PENDING = 2'b10,
    WD_FIRED   = 2'b11
  } wtu_state_type;

  wtu_state_type      state_reg;
  logic [ADDR_W-1:0]  awaddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               aw_full_reg;
  logic               w_full_reg;
  logic               awready_reg;
  logic               wready_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               arready_reg;
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  logic [1:0]         rresp_reg;
  logic [31:0]        timeout_reload_value_reg;
  logic               irq_enable_reg;
  logic               reset_output_enable_reg;
  logic               nmi_reg;
  logic               sys_reset_reg;

  logic               wr_go;
  wtu_pkg::wtu_sel_type wr_sel;
  wtu_pkg::wtu_sel_type rd_sel;
  logic               locked;
  logic               wr_allowed;
  logic               reload_write;
  logic               ctrl_write;
  logic               iclr_write;
  logic               lock_write;
  logic               enable_rise;
  logic [31:0]        count;
  logic               at_zero;
  logic               timeout;
  logic               counter_load;
  logic               raw_irq;
  logic [31:0]        reload_merged;
  logic [31:0]        read_word;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic wtu_pkg::wtu_sel_type decode_addr(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    case (a)
      wtu_pkg::OFS_RELOAD: decode_addr = wtu_pkg::SEL_RELOAD;
      wtu_pkg::OFS_VALUE:  decode_addr = wtu_pkg::SEL_VALUE;
      wtu_pkg::OFS_CTRL:   decode_addr = wtu_pkg::SEL_CTRL;
      wtu_pkg::OFS_ICLR:   decode_addr = wtu_pkg::SEL_ICLR;
      wtu_pkg::OFS_RAW:    decode_addr = wtu_pkg::SEL_RAW;
      wtu_pkg::OFS_MASKED: decode_addr = wtu_pkg::SEL_MASKED;
      wtu_pkg::OFS_LOCK:   decode_addr = wtu_pkg::SEL_LOCK;
      default:             decode_addr = wtu_pkg::SEL_NONE;
    endcase
  endfunction

  assign wr_sel = decode_addr(awaddr_reg);
  assign rd_sel = decode_addr(s_axi_araddr);

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  // Address and data are latched independently so either may come first
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      awaddr_reg  <= '0;
    end
    else if (ce)
    begin
      if (awready_reg && s_axi_awvalid)
      begin
        awaddr_reg  <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      else if (wr_go)
        aw_full_reg <= 1'b0;
      else if (bvalid_reg && s_axi_bready)
        awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (ce)
    begin
      if (wready_reg && s_axi_wvalid)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      else if (wr_go)
        w_full_reg <= 1'b0;
      else if (bvalid_reg && s_axi_bready)
        wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= wtu_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_sel == wtu_pkg::SEL_NONE) ? wtu_pkg::RESP_SLVERR : wtu_pkg::RESP_OKAY;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write effects
  // ----------------------------------------
  // Locked writes still answer OKAY; all but lock register writes are dropped silently
  assign wr_allowed   = wr_go && !locked;
  assign reload_write = wr_allowed && (wr_sel == wtu_pkg::SEL_RELOAD);
  assign ctrl_write   = wr_allowed && (wr_sel == wtu_pkg::SEL_CTRL) && !irq_enable_reg
                        && wstrb_reg[0];
  assign iclr_write   = wr_allowed && (wr_sel == wtu_pkg::SEL_ICLR);
  assign lock_write   = wr_go && (wr_sel == wtu_pkg::SEL_LOCK);
  assign enable_rise  = ctrl_write && wdata_reg[wtu_pkg::CTRL_IRQ_EN_BIT];

  // Byte enables merge only into the reload value; control writes need byte 0 enabled
  always_comb
  begin
    reload_merged = timeout_reload_value_reg;
    for (int i = 0; i < 4; i++)
    begin
      if (wstrb_reg[i])
        reload_merged[i*8 +: 8] = wdata_reg[i*8 +: 8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timeout_reload_value_reg <= wtu_pkg::RELOAD_RESET;
    else if (ce && reload_write)
      timeout_reload_value_reg <= reload_merged;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_enable_reg          <= 1'b0;
      reset_output_enable_reg <= 1'b0;
    end
    else if (ce && ctrl_write)
    begin
      irq_enable_reg          <= wdata_reg[wtu_pkg::CTRL_IRQ_EN_BIT];
      reset_output_enable_reg <= wdata_reg[wtu_pkg::CTRL_RES_EN_BIT];
    end
  end

  wtu_lock_guard u_lock_guard (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .lock_write (lock_write),
    .lock_data  (wdata_reg),
    .locked     (locked)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // A reload of zero makes the very next cycle a time-out
  assign timeout      = irq_enable_reg && at_zero && !reload_write && !iclr_write;
  assign counter_load = enable_rise || reload_write || iclr_write || timeout;

  wtu_down_counter #(
    .WIDTH       (32),
    .RESET_VALUE (wtu_pkg::RELOAD_RESET)
  ) u_counter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .run        (irq_enable_reg),
    .load       (counter_load),
    .load_value (reload_write ? reload_merged : timeout_reload_value_reg),
    .count      (count),
    .at_zero    (at_zero)
  );

  // ----------------------------------------
  // Time-out sequencing
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= WD_IDLE;
    else if (ce)
    begin
      case (state_reg)
        WD_IDLE:
          if (enable_rise)
            state_reg <= WD_RUN;
        WD_RUN:
          if (timeout)
            state_reg <= WD_PENDING;
        WD_PENDING:
          if (timeout && reset_output_enable_reg)
            state_reg <= WD_FIRED;
          else if (iclr_write)
            state_reg <= WD_RUN;
        WD_FIRED:
          if (iclr_write)
            state_reg <= WD_RUN;
        default:
          state_reg <= WD_IDLE;
      endcase
    end
  end

  assign raw_irq = (state_reg == WD_PENDING) || (state_reg == WD_FIRED);

  // The interrupt line has no mask of its own; the processor treats it as NMI
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nmi_reg <= 1'b0;
    else if (ce)
      nmi_reg <= (raw_irq || (state_reg == WD_RUN && timeout)) && irq_enable_reg;
  end

  // Reset request is held until hardware reset; it ends its own cause
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sys_reset_reg <= 1'b0;
    else if (ce && state_reg == WD_PENDING && timeout && reset_output_enable_reg)
      sys_reset_reg <= 1'b1;
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  always_comb
  begin
    read_word = '0;
    case (rd_sel)
      wtu_pkg::SEL_RELOAD: read_word = timeout_reload_value_reg;
      wtu_pkg::SEL_VALUE:  read_word = count;
      wtu_pkg::SEL_CTRL:   read_word = {30'h0, reset_output_enable_reg, irq_enable_reg};
      wtu_pkg::SEL_RAW:    read_word = {31'h0, raw_irq};
      wtu_pkg::SEL_MASKED: read_word = {31'h0, raw_irq && irq_enable_reg};
      wtu_pkg::SEL_LOCK:   read_word = {31'h0, locked};
      default:             read_word = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= wtu_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arready_reg && s_axi_arvalid)
      begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= read_word;
        rresp_reg   <= (rd_sel == wtu_pkg::SEL_NONE) ? wtu_pkg::RESP_SLVERR : wtu_pkg::RESP_OKAY;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign nmi_request          = nmi_reg;
  assign system_reset_request = sys_reset_reg;

endmodule

// ---- shared/wtu_pkg.sv ----
// Shared constants for the watchdog time-out unit.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
package wtu_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFS_RELOAD = 12'h000;
  localparam logic [11:0] OFS_VALUE  = 12'h004;
  localparam logic [11:0] OFS_CTRL   = 12'h008;
  localparam logic [11:0] OFS_ICLR   = 12'h00c;
  localparam logic [11:0] OFS_RAW    = 12'h010;
  localparam logic [11:0] OFS_MASKED = 12'h014;
  localparam logic [11:0] OFS_LOCK   = 12'hc00;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int          CTRL_IRQ_EN_BIT = 0;
  localparam int          CTRL_RES_EN_BIT = 1;
  localparam logic [31:0] RELOAD_RESET    = 32'hffff_ffff;
  localparam logic [31:0] UNLOCK_KEY      = 32'h1acc_e551;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // ----------------------------------------
  // Register select codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEL_RELOAD = 3'b000,
    SEL_VALUE  = 3'b001,
    SEL_CTRL   = 3'b010,
    SEL_ICLR   = 3'b011,
    SEL_RAW    = 3'b100,
    SEL_MASKED = 3'b101,
    SEL_LOCK   = 3'b110,
    SEL_NONE   = 3'b111
  } wtu_sel_type;

endpackage

// ---- design/wtu_down_counter.sv ----
// Loadable down counter that stops at zero.
// Assumes the parent reloads it whenever it sees the zero flag while running.
`timescale 1ns/1ps
module wtu_down_counter #(
  parameter int          WIDTH       = 32,
  parameter logic [31:0] RESET_VALUE = wtu_pkg::RELOAD_RESET
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count,
  output logic                  at_zero
);

  logic [WIDTH-1:0] count_reg;

  // ----------------------------------------
  // Count
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= RESET_VALUE[WIDTH-1:0];
    else if (ce)
    begin
      if (load)
        count_reg <= load_value;
      else if (run && (count_reg != '0))
        count_reg <= count_reg - WIDTH'(1);
    end
  end

  assign count   = count_reg;
  assign at_zero = (count_reg == '0);

endmodule

// ---- design/wtu_lock_guard.sv ----
// Full-register lock with unlock key.
// Assumes lock_write is a one-cycle pulse per accepted bus write.
`timescale 1ns/1ps
module wtu_lock_guard (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        lock_write,
  input  wire logic [31:0] lock_data,
  output logic             locked
);

  logic locked_reg;

  // ----------------------------------------
  // Lock state
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      locked_reg <= 1'b0;
    else if (ce && lock_write)
      locked_reg <= (lock_data != wtu_pkg::UNLOCK_KEY);
  end

  assign locked = locked_reg;

endmodule

// ---- verif/wtu_watchdog_assertions.sv ----
// Concurrent checks on the watchdog top-level ports.
// Assumes it is bound into wtu_watchdog from the bench top file.
`timescale 1ns/1ps
module wtu_watchdog_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              nmi_request,
  input wire logic              system_reset_request
);
  // ----------------------------------------
  // Address capture for response checks
  // ----------------------------------------
  logic [ADDR_W-1:0] aw_reg;
  logic [ADDR_W-1:0] ar_reg;

  always_ff @(posedge aclk)
    if (s_axi_awvalid && s_axi_awready && ce)
      aw_reg <= s_axi_awaddr;

  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready && ce)
      ar_reg <= s_axi_araddr;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {wtu_pkg::OFS_RELOAD, wtu_pkg::OFS_VALUE, wtu_pkg::OFS_CTRL, wtu_pkg::OFS_ICLR,
                     wtu_pkg::OFS_RAW, wtu_pkg::OFS_MASKED, wtu_pkg::OFS_LOCK};
  endfunction

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both halves latch at the take edge, execute one edge later, so bvalid is seen two edges on
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
    |=> ##1 s_axi_bvalid) else $error("write response missing one cycle after execution");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read data missing after address take");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while a response is pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data pending");
  wr_resp_a: assert property ($rose(s_axi_bvalid) |-> (s_axi_bresp == wtu_pkg::RESP_SLVERR) == !mapped(aw_reg))
    else $error("write response code does not match address");
  rd_resp_a: assert property (s_axi_rvalid |-> (s_axi_rresp == wtu_pkg::RESP_SLVERR) == !mapped(ar_reg))
    else $error("read response code does not match address");
  rst_sticky_a: assert property (system_reset_request |=> system_reset_request)
    else $error("system reset request dropped without hardware reset");
  rst_cause_a: assert property ($rose(system_reset_request) |-> $past(nmi_request))
    else $error("system reset request without pending interrupt");
  nmi_clear_a: assert property ($fell(nmi_request) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a register write");
  rst_idle_a: assert property ($rose(aresetn) |-> !nmi_request && !system_reset_request && !s_axi_bvalid)
    else $error("outputs not idle after reset release");
endmodule

// ---- verif/wtu_reset_sink.sv ----
// Model of the system reset logic and interrupt controller input.
// Assumes level requests from the watchdog, sampled on aclk.
`timescale 1ns/1ps
module wtu_reset_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nmi_request,
  input wire logic system_reset_request,
  output logic [7:0] nmi_events,
  output logic       reset_seen
);
  logic nmi_prev;

  // Nonmaskable: every rising request is taken, nothing can mask it
  always_ff @(posedge aclk)
  begin
    nmi_prev <= aresetn ? nmi_request : 1'b0;
    if (!aresetn)
      nmi_events <= 8'h00;
    else if (nmi_request && !nmi_prev)
      nmi_events <= nmi_events + 8'h01;
  end

  // Reset latched until hardware reset, as the real reset logic would
  always_ff @(posedge aclk)
    reset_seen <= aresetn && (reset_seen || system_reset_request);
endmodule

// ---- verif/wtu_watchdog_tb.sv ----
// Self-checking bench for the watchdog time-out unit.
// Assumes package, design, checker and reset sink are compiled first.
`timescale 1ns/1ps
module wtu_watchdog_tb;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1; // Peripheral clock ungated except for the ten-edge clock enable test
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, v, v2;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, nmi, sreq, reset_seen;
  logic [1:0]  bresp, rresp, last_resp;
  logic [7:0]  nmi_events;
  int          failures = 0, n_checks = 0, cyc = 0;

  wtu_watchdog u_wtu_watchdog (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nmi_request(nmi), .system_reset_request(sreq));
  wtu_reset_sink u_wtu_reset_sink (.aclk(aclk), .aresetn(aresetn), .nmi_request(nmi),
    .system_reset_request(sreq), .nmi_events(nmi_events), .reset_seen(reset_seen));

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    last_resp = rresp;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Count read shortly after a load must sit just below the loaded value
  function automatic logic [31:0] inwin(input logic [31:0] x, input logic [31:0] top);
    return {31'h0, x <= top && x > top - 32'h10};
  endfunction

  task automatic wait_sig(input bit use_rst, input int m);
    for (int i = 0; i < m && !(use_rst ? sreq : nmi); i++) @(posedge aclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Whole run needs well under 6000 cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(wtu_pkg::OFS_RELOAD, wtu_pkg::RELOAD_RESET);
    rdchk(wtu_pkg::OFS_VALUE, wtu_pkg::RELOAD_RESET);
    rdchk(wtu_pkg::OFS_CTRL, 32'h0);
    rdchk(wtu_pkg::OFS_RAW, 32'h0);
    rdchk(wtu_pkg::OFS_MASKED, 32'h0);
    rdchk(wtu_pkg::OFS_LOCK, 32'h0);
    rdchk(12'h020, 32'h0);
    chk(last_resp, wtu_pkg::RESP_SLVERR);
    $display("test reset values done");
    wr(wtu_pkg::OFS_LOCK, 32'h5);
    rdchk(wtu_pkg::OFS_LOCK, 32'h1);
    wr(wtu_pkg::OFS_RELOAD, 32'h40);
    rdchk(wtu_pkg::OFS_RELOAD, wtu_pkg::RELOAD_RESET);
    wr(wtu_pkg::OFS_CTRL, 32'h3);
    rdchk(wtu_pkg::OFS_CTRL, 32'h0);
    wr(wtu_pkg::OFS_LOCK, wtu_pkg::UNLOCK_KEY);
    rdchk(wtu_pkg::OFS_LOCK, 32'h0);
    wr(12'h018, 32'h1);
    chk(last_resp, wtu_pkg::RESP_SLVERR);
    $display("test lock done");
    // Byte strobes merge into the reload value: low byte replaced, rest kept
    wstrb <= 4'h1;
    wr(wtu_pkg::OFS_RELOAD, 32'h0000_0040);
    wstrb <= 4'hf;
    rdchk(wtu_pkg::OFS_RELOAD, 32'hffff_ff40);
    wr(wtu_pkg::OFS_RELOAD, 32'h40);
    wr(wtu_pkg::OFS_CTRL, 32'h2);
    rdchk(wtu_pkg::OFS_CTRL, 32'h2);
    wr(wtu_pkg::OFS_CTRL, 32'h3);
    rdchk(wtu_pkg::OFS_CTRL, 32'h3);
    wr(wtu_pkg::OFS_CTRL, 32'h0);
    rdchk(wtu_pkg::OFS_CTRL, 32'h3);
    rd(wtu_pkg::OFS_VALUE, v);
    chk(inwin(v, 32'h40), 32'h1);
    wr(wtu_pkg::OFS_RELOAD, 32'h300);
    rd(wtu_pkg::OFS_VALUE, v);
    chk(inwin(v, 32'h300), 32'h1);
    $display("test start done");
    wait_sig(1'b0, 32'h320);
    chk(nmi, 1'b1);
    rdchk(wtu_pkg::OFS_MASKED, 32'h1);
    rd(wtu_pkg::OFS_VALUE, v);
    chk(inwin(v, 32'h300), 32'h1);
    chk(sreq, 1'b0);
    chk(nmi_events, 8'h01);
    wr(wtu_pkg::OFS_RELOAD, 32'h300);
    rdchk(wtu_pkg::OFS_RAW, 32'h1);
    wr(wtu_pkg::OFS_ICLR, 32'h0);
    rdchk(wtu_pkg::OFS_RAW, 32'h0);
    chk(nmi, 1'b0);
    rd(wtu_pkg::OFS_VALUE, v);
    chk(inwin(v, 32'h300), 32'h1);
    $display("test first time-out done");
    wait_sig(1'b0, 32'h320);
    wait_sig(1'b1, 32'h320);
    chk(sreq, 1'b1);
    repeat (4) @(posedge aclk);
    chk(reset_seen, 1'b1);
    $display("test second time-out done");
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(sreq, 1'b0);
    rdchk(wtu_pkg::OFS_CTRL, 32'h0);
    rdchk(wtu_pkg::OFS_VALUE, wtu_pkg::RELOAD_RESET);
    wr(wtu_pkg::OFS_RELOAD, 32'h100);
    wr(wtu_pkg::OFS_CTRL, 32'h1);
    rdchk(wtu_pkg::OFS_RAW, 32'h0);
    // Clock enable low for ten edges must freeze the count; only the two read edges count down
    rd(wtu_pkg::OFS_VALUE, v);
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    rd(wtu_pkg::OFS_VALUE, v2);
    chk(v2, v - 32'h2);
    $display("test clock enable done");
    wr(wtu_pkg::OFS_RELOAD, 32'h0);
    wait_sig(1'b0, 4);
    chk(nmi, 1'b1);
    repeat (64) @(posedge aclk);
    chk(sreq, 1'b0);
    $display("test zero reload done");
    give_verdict();
  end
endmodule

bind wtu_watchdog wtu_watchdog_checker #(.ADDR_W(ADDR_W)) u_wtu_watchdog_checker (.*);
